// file: core/cslp_pkg.sv
`default_nettype none
package cslp_pkg;
    // number of peripherals that can be gated individually
    localparam int unsigned NUM_PERIPH = 8;
    localparam logic [7:0] PERIPH_EN_RESET = 8'hFF;
    localparam int unsigned PC_WIDTH = 16;
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [15:0] PC_STEP = 16'h0001;
    // core states, Gray along run -> sleep -> wake
    typedef enum logic [1:0] {
        CSLP_RUN = 2'b00,
        CSLP_SLEEP = 2'b01,
        CSLP_WAKE = 2'b11
    } cslp_state_t;
endpackage
`default_nettype wire

// file: core/cslp_sync.sv
`timescale 1ns/1ns
`default_nettype none
// two-flop synchroniser for asynchronous reset sources
module cslp_sync #(
    parameter int unsigned WIDTH = 4
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    always_comb
    begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;
endmodule
`default_nettype wire

// file: core/cslp_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module cslp_ctrl (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic sleep_instr_in,
    input wire logic irq_pending_in,
    input wire logic wdt_enable_in,
    input wire logic wdt_timeout_irq_in,
    input wire logic wdt_timeout_rst_in,
    input wire logic por_in,
    input wire logic brownout_in,
    input wire logic ext_reset_b_in,
    input wire logic [7:0] periph_en_in,
    output logic core_run_out,
    output logic core_reset_out,
    output logic irq_service_out,
    output logic [15:0] pc_out,
    output logic sleeping_out,
    output logic osc_en_out,
    output logic sysclk_en_out,
    output logic wdt_osc_en_out,
    output logic wdt_count_en_out,
    output logic [7:0] periph_clk_en_out
);
    logic [3:0] async_w;
    logic [3:0] sync_w;
    logic por_s;
    logic bo_s;
    logic ext_rst_s;
    logic wdt_rst_s;
    logic any_reset;
    logic wake_irq;

    assign async_w = {wdt_timeout_rst_in, ~ext_reset_b_in, brownout_in, por_in};

    cslp_sync #(.WIDTH(4)) u_sync (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .async_in(async_w),
        .sync_out(sync_w)
    );

    assign por_s = sync_w[0];
    assign bo_s = sync_w[1];
    assign ext_rst_s = sync_w[2];
    assign wdt_rst_s = sync_w[3];
    assign any_reset = por_s | bo_s | ext_rst_s | wdt_rst_s;
    assign wake_irq = irq_pending_in | wdt_timeout_irq_in;

    cslp_pkg::cslp_state_t state_q;
    cslp_pkg::cslp_state_t state_d;
    logic [15:0] pc_q;
    logic [15:0] pc_d;
    logic core_run_q;
    logic core_run_d;
    logic core_reset_q;
    logic core_reset_d;
    logic irq_service_q;
    logic irq_service_d;
    logic sleeping_q;
    logic sleeping_d;
    logic wdt_count_q;
    logic wdt_count_d;
    logic [7:0] periph_q;
    logic [7:0] periph_d;

    always_comb
    begin
        state_d = state_q;
        pc_d = pc_q;
        irq_service_d = 1'b0;
        core_reset_d = 1'b0;
        if (any_reset)
        begin
            // reset wakes and reruns reset sequencing
            state_d = cslp_pkg::CSLP_RUN;
            pc_d = cslp_pkg::PC_RESET;
            core_reset_d = 1'b1;
        end
        else
        begin
            case (state_q)
                cslp_pkg::CSLP_RUN:
                begin
                    // sleep entry, counter frozen at this point
                    if (sleep_instr_in)
                        state_d = cslp_pkg::CSLP_SLEEP;
                    else
                        pc_d = pc_q + cslp_pkg::PC_STEP;
                end
                cslp_pkg::CSLP_SLEEP:
                begin
                    if (wake_irq)
                        state_d = cslp_pkg::CSLP_WAKE;
                end
                cslp_pkg::CSLP_WAKE:
                begin
                    irq_service_d = 1'b1;
                    state_d = cslp_pkg::CSLP_RUN;
                end
                default:
                    state_d = cslp_pkg::CSLP_RUN;
            endcase
        end
        core_run_d = (state_d == cslp_pkg::CSLP_RUN) && !core_reset_d;
        sleeping_d = (state_d == cslp_pkg::CSLP_SLEEP);
        // watchdog counts when enabled, sleep or not
        wdt_count_d = wdt_enable_in;
        // per-peripheral gating independent of sleep state
        periph_d = periph_en_in;
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            state_q <= cslp_pkg::CSLP_RUN;
            pc_q <= cslp_pkg::PC_RESET;
            core_run_q <= 1'b0;
            core_reset_q <= 1'b1;
            irq_service_q <= 1'b0;
            sleeping_q <= 1'b0;
            wdt_count_q <= 1'b0;
            periph_q <= cslp_pkg::PERIPH_EN_RESET;
        end
        else
        begin
            state_q <= state_d;
            pc_q <= pc_d;
            core_run_q <= core_run_d;
            core_reset_q <= core_reset_d;
            irq_service_q <= irq_service_d;
            sleeping_q <= sleeping_d;
            wdt_count_q <= wdt_count_d;
            periph_q <= periph_d;
        end
    end

    // clocks and oscillators never gated by sleep
    // only the block's own reset drops them; sleep saves core power alone
    logic osc_q;
    logic osc_d;
    always_comb
    begin
        osc_d = 1'b1;
    end
    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
            osc_q <= 1'b0;
        else
            osc_q <= osc_d;
    end

    assign core_run_out = core_run_q;
    assign core_reset_out = core_reset_q;
    assign irq_service_out = irq_service_q;
    assign pc_out = pc_q;
    assign sleeping_out = sleeping_q;
    assign osc_en_out = osc_q;
    assign sysclk_en_out = osc_q;
    assign wdt_osc_en_out = osc_q;
    assign wdt_count_en_out = wdt_count_q;
    assign periph_clk_en_out = periph_q;

    pc_hold_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        sleeping_out && $past(sleeping_out) |-> $stable(pc_out))
        else $error("program counter moved in sleep");
    sleep_entry_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        core_run_out && sleep_instr_in && !any_reset |=> sleeping_out && !core_run_out)
        else $error("sleep not entered");
    clk_alive_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        sleeping_out |-> osc_en_out && sysclk_en_out)
        else $error("clock stopped in sleep");
    wdt_runs_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        $past(wdt_enable_in) && osc_en_out |-> wdt_count_en_out && wdt_osc_en_out)
        else $error("watchdog halted");
    periph_follow_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        1'b1 |=> periph_clk_en_out == $past(periph_en_in))
        else $error("peripheral gating wrong");
    irq_wake_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        sleeping_out && wake_irq && !any_reset |=> !sleeping_out ##1 irq_service_out && core_run_out)
        else $error("interrupt wake failed");
    rst_wake_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        any_reset |=> core_reset_out && !sleeping_out && pc_out == cslp_pkg::PC_RESET)
        else $error("reset wake failed");
    irq_resume_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        irq_service_out |-> pc_out == $past(pc_out, 2))
        else $error("resume counter wrong");
    // counter steps once per running cycle
    pc_run_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        core_run_out && $past(core_run_out) |-> pc_out == $past(pc_out) + cslp_pkg::PC_STEP)
        else $error("program counter did not step");
    periph_indep_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        $rose(sleeping_out) |-> periph_clk_en_out == $past(periph_en_in))
        else $error("sleep changed gating");

    sleep_c: cover property (@(posedge clk_in) disable iff (!rst_b_in) $rose(sleeping_out));
    irq_wake_c: cover property (@(posedge clk_in) disable iff (!rst_b_in) irq_service_out);
    rst_wake_c: cover property (@(posedge clk_in) disable iff (!rst_b_in)
        sleeping_out ##1 core_reset_out);
    wdt_wake_c: cover property (@(posedge clk_in) disable iff (!rst_b_in)
        sleeping_out && wdt_timeout_irq_in);
endmodule
`default_nettype wire

// file: bench/cslp_core_model.sv
`timescale 1ns/1ns
`default_nettype none
// processor core and interrupt source as seen by the sleep controller
module cslp_core_model (
    input wire logic clk_in,
    input wire logic core_run_in,
    input wire logic irq_service_in,
    input wire logic want_sleep_in,
    input wire logic irq_req_in,
    output var logic sleep_instr_out = 1'b0,
    output var logic irq_pending_out = 1'b0
);
    // sleep opcode only issues while the core runs, one cycle per fetch
    always @(negedge clk_in)
        sleep_instr_out <= want_sleep_in && core_run_in && !sleep_instr_out;
    // pending stays up until the core is told to serve it
    always @(negedge clk_in)
        irq_pending_out <= irq_req_in | (irq_pending_out & ~irq_service_in);
endmodule
`default_nettype wire

// file: bench/cslp_ctrl_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin miscompares++; \
    $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module cslp_ctrl_tb_top;
    logic clk = 1'b0, rst_b = 1'b0, want = 1'b0, irq_req = 1'b0, sleep_i, irq_p;
    logic wdt_en = 1'b0, wdt_irq = 1'b0, wdt_rst = 1'b0, por = 1'b0, bo = 1'b0, ext_b = 1'b1;
    logic [7:0] pen = 8'hFF, pclk;
    logic run, crst, srv, slp, osc, sclk, wosc, wcnt;
    logic [15:0] pc, p;
    int miscompares = 0, tests_run = 0;
    always #4 clk = ~clk;
    cslp_core_model CORE (.clk_in(clk), .core_run_in(run), .irq_service_in(srv), .want_sleep_in(want),
        .irq_req_in(irq_req), .sleep_instr_out(sleep_i), .irq_pending_out(irq_p));
    cslp_ctrl DUT (.clk_in(clk), .rst_b_in(rst_b), .sleep_instr_in(sleep_i), .irq_pending_in(irq_p),
        .wdt_enable_in(wdt_en), .wdt_timeout_irq_in(wdt_irq), .wdt_timeout_rst_in(wdt_rst), .por_in(por),
        .brownout_in(bo), .ext_reset_b_in(ext_b), .periph_en_in(pen), .core_run_out(run),
        .core_reset_out(crst), .irq_service_out(srv), .pc_out(pc), .sleeping_out(slp), .osc_en_out(osc),
        .sysclk_en_out(sclk), .wdt_osc_en_out(wosc), .wdt_count_en_out(wcnt), .periph_clk_en_out(pclk));
    task automatic finish_test();
        $display("compares %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic go_sleep();
        // non-blocking: the core model samples on this same falling edge
        want <= 1'b1;
        for (int i = 0; i < 20 && slp !== 1'b1; i++)
            @(negedge clk);
        want <= 1'b0;
        `CHK(slp, 1'b1)
        `CHK(pclk, pen)
    endtask
    // sleep holds the core, keeps clocks and peripherals, wakes on interrupt
    task automatic t_wake(input bit use_wdt);
        go_sleep();
        p = pc;
        repeat (5) @(negedge clk);
        `CHK(pc, p)
        `CHK(run, 1'b0)
        `CHK({osc, sclk}, 2'h3)
        `CHK(wosc, 1'b1)
        wdt_en = 1'b1;
        pen = 8'h3C;
        @(negedge clk);
        `CHK(wcnt, 1'b1)
        `CHK(pclk, 8'h3C)
        if (use_wdt)
            wdt_irq = 1'b1;
        else
            irq_req <= 1'b1;
        @(negedge clk);
        {wdt_irq, wdt_en, pen} = {2'h0, 8'hFF};
        irq_req <= 1'b0;
        for (int i = 0; i < 6 && srv !== 1'b1; i++)
            @(negedge clk);
        `CHK(wcnt, 1'b0)
        `CHK(slp, 1'b0)
        `CHK({srv, run}, 2'h3)
        `CHK(pc, p)
        $display("wake test done");
    endtask
    // every reset source ends sleep through a core reset
    task automatic t_rst_wake(input int k);
        go_sleep();
        {wdt_rst, por, bo, ext_b} = 4'h1 ^ (4'h8 >> k);
        for (int i = 0; i < 8 && crst !== 1'b1; i++)
            @(negedge clk);
        `CHK(crst, 1'b1)
        `CHK({slp, pc}, 17'h0_0000)
        {wdt_rst, por, bo, ext_b} = 4'h1;
        repeat (6) @(negedge clk);
        `CHK(run, 1'b1)
        $display("reset wake %0d done", k);
    endtask
    // gating each peripheral on its own
    task automatic t_periph();
        for (int i = 0; i < 8; i++)
        begin
            pen = ~(8'h01 << i);
            @(negedge clk);
            `CHK(pclk, ~(8'h01 << i))
        end
        pen = 8'hFF;
        @(negedge clk);
        $display("peripheral test done");
    endtask
    // reset holds the core and keeps the clocks off until release
    task automatic t_reset();
        repeat (6) @(negedge clk);
        `CHK({crst, run, pc, osc}, 19'h4_0000)
        `CHK(pclk, 8'hFF)
        `CHK({slp, srv, wcnt}, 3'h0)
        rst_b = 1'b1;
        repeat (3) @(negedge clk);
        `CHK({osc, sclk, wosc}, 3'h7)
        `CHK(pc !== 16'h0000, 1'b1)
        $display("reset test done");
    endtask
    initial
    begin
        t_reset();
        t_periph();
        t_wake(1'b0);
        t_wake(1'b1);
        // index 0 is the watchdog time-out configured as reset
        t_rst_wake(0);
        for (int k = 1; k < 4; k++)
            t_rst_wake(k);
        finish_test();
    end
    // whole run is about a hundred cycles
    initial
    begin
        #20000;
        miscompares++;
        finish_test();
    end
endmodule
`default_nettype wire
